//--- fru_unit.sv
// Execution unit for unary file register operations
`timescale 1ns/1ps
`default_nettype none
`include "fru_defines.svh"
module fru_unit (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic op_valid_i,          // Instruction in execute this cycle
  input wire logic [2:0] op_i,          // Operation code (fru_op_e)
  input wire logic [6:0] file_addr_i,   // File register address
  input wire logic dest_i,              // 0 accumulator, 1 file register
  output logic [7:0] acc_o,             // Working accumulator
  output logic zero_o,                  // Zero flag
  output logic [7:0] file_data_o,       // Read port data
  output logic skip_o,                  // Next instruction is a no-operation
  output logic busy_o                   // Slot being replaced, input ignored
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic {
    FRU_RUN,
    FRU_SKIP
  } fru_state_e;

  typedef struct packed {
    fru_state_e state;
    logic [7:0] acc;
    logic zero;
    logic skip;
    logic [7:0] rd_data; // Read port data
  } fru_st_s;

  fru_st_s st;      // Registered state
  fru_st_s next_st; // Next state
  logic [7:0] file_mem [`FRU_FILE_DEPTH]; // File registers
  logic [7:0] file_rd;                    // Operand read
  logic issue;                            // Instruction accepted
  fru_alu_if alu_bus ();

  // ****************************************
  // Operand fetch and ALU
  // ****************************************
  assign file_rd = file_mem[file_addr_i]; // Full 0..127 range
  assign issue = op_valid_i && (st.state == FRU_RUN);
  assign alu_bus.op = issue ? fru_pkg::fru_op_e'(op_i) : fru_pkg::FRU_NOP;
  assign alu_bus.dest = dest_i;
  assign alu_bus.operand = file_rd;

  fru_alu u_alu (
    .bus(alu_bus)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.skip = 1'b0;
    next_st.rd_data = file_rd; // Read port follows address every cycle
    case (st.state)
      FRU_RUN: begin
        if (alu_bus.res.write_acc) begin
          next_st.acc = alu_bus.res.result;
        end
        if (alu_bus.res.zero_we) begin
          next_st.zero = alu_bus.res.zero_val;
        end
        if (alu_bus.res.skip) begin
          next_st.state = FRU_SKIP; // Squash next slot
          next_st.skip = 1'b1;
        end
      end
      FRU_SKIP: begin
        next_st.state = FRU_RUN; // Normal flow resumes
      end
      default: begin
        next_st.state = FRU_RUN;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '{state: FRU_RUN, acc: `FRU_ACC_RESET, zero: `FRU_ZERO_RESET, skip: 1'b0,
        rd_data: `FRU_DATA_ZERO};
    end else begin
      st <= next_st;
    end
  end

  // File register write port, no reset
  always_ff @(posedge ref_clk_i) begin
    if (alu_bus.res.write_file) begin
      file_mem[file_addr_i] <= alu_bus.res.result;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign acc_o = st.acc;
  assign zero_o = st.zero;
  assign skip_o = st.skip;
  assign file_data_o = st.rd_data;
  assign busy_o = (st.state == FRU_SKIP);
endmodule : fru_unit
`default_nettype wire

//--- fru_defines.svh
// Constants and types for the file register unary operation unit
// How it works
// - Seven-bit file address plus destination bit
// - Complement inverts file, destination bit picks target
// - Clear file writes zero, sets zero flag
// - Decrement subtracts one, destination bit picks target
// - Clear accumulator loads zero, sets zero flag
// - Decrement-skip subtracts one to chosen target
// - Zero decrement-skip result inserts no-operation cycle
// - Nonzero skip result executes next instruction normally
// - Increment-skip adds one to chosen target
// - Zero increment-skip result inserts no-operation cycle
`ifndef FRU_DEFINES_SVH
`define FRU_DEFINES_SVH
// ****************************************
// Widths and reset values
// ****************************************
`define FRU_ADDR_W 7
`define FRU_DATA_W 8
`define FRU_FILE_DEPTH 128
`define FRU_ACC_RESET 8'h00
`define FRU_ZERO_RESET 1'b0
`define FRU_DATA_ZERO 8'h00
`define FRU_DATA_ONE 8'h01
`define FRU_DEST_ACC 1'b0
`define FRU_DEST_FILE 1'b1
`endif

//--- fru_pkg.sv
// Types shared by the file register unary operation unit
`default_nettype none
`include "fru_defines.svh"
package fru_pkg;
  // Operation selector
  typedef enum logic [2:0] {
    FRU_NOP,
    FRU_COMPLEMENT_FILE_OP,
    FRU_CLEAR_FILE_OP,
    FRU_DECREMENT_FILE_OP,
    FRU_CLEAR_ACCUMULATOR_OP,
    FRU_DECREMENT_SKIP_ZERO_OP,
    FRU_INCREMENT_SKIP_ZERO_OP
  } fru_op_e;
  // Combinational result of one operation
  typedef struct packed {
    logic [7:0] result;
    logic write_acc;
    logic write_file;
    logic zero_we;
    logic zero_val;
    logic skip;
  } fru_res_s;
endpackage : fru_pkg
`default_nettype wire

//--- fru_if.sv
// Interface carrying operand and result between the unit and its ALU
`timescale 1ns/1ps
`default_nettype none
interface fru_alu_if;
  fru_pkg::fru_op_e op;   // Operation in execute
  logic dest;             // Destination select
  logic [7:0] operand;    // File register value
  fru_pkg::fru_res_s res; // Computed result
  modport core (output op, output dest, output operand, input res);
  modport alu (input op, input dest, input operand, output res);
endinterface : fru_alu_if
`default_nettype wire

//--- fru_alu.sv
// Combinational ALU for the unary file register operations
`timescale 1ns/1ps
`default_nettype none
`include "fru_defines.svh"
module fru_alu (
  fru_alu_if.alu bus
);
  // ****************************************
  // Result selection
  // ****************************************
  // Target decode, used twice per branch that honours the destination bit
  function automatic logic to_file(input logic d);
    to_file = (d == `FRU_DEST_FILE);
  endfunction : to_file

  always_comb begin
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    dec_v = bus.operand - `FRU_DATA_ONE; // Wraps modulo 256
    inc_v = bus.operand + `FRU_DATA_ONE; // Wraps modulo 256
    bus.res = '0;
    case (bus.op)
      fru_pkg::FRU_COMPLEMENT_FILE_OP: begin
        bus.res.result = ~bus.operand;
        bus.res.write_file = to_file(bus.dest);
        bus.res.write_acc = !to_file(bus.dest);
        bus.res.zero_we = 1'b1;
        bus.res.zero_val = (~bus.operand == `FRU_DATA_ZERO);
      end
      fru_pkg::FRU_CLEAR_FILE_OP: begin
        bus.res.result = `FRU_DATA_ZERO;
        bus.res.write_file = 1'b1;
        bus.res.zero_we = 1'b1;
        bus.res.zero_val = 1'b1;
      end
      fru_pkg::FRU_DECREMENT_FILE_OP: begin
        bus.res.result = dec_v;
        bus.res.write_file = to_file(bus.dest);
        bus.res.write_acc = !to_file(bus.dest);
        bus.res.zero_we = 1'b1;
        bus.res.zero_val = (dec_v == `FRU_DATA_ZERO);
      end
      fru_pkg::FRU_CLEAR_ACCUMULATOR_OP: begin
        bus.res.result = `FRU_DATA_ZERO;
        bus.res.write_acc = 1'b1;
        bus.res.zero_we = 1'b1;
        bus.res.zero_val = 1'b1;
      end
      fru_pkg::FRU_DECREMENT_SKIP_ZERO_OP: begin
        bus.res.result = dec_v;
        bus.res.write_file = to_file(bus.dest);
        bus.res.write_acc = !to_file(bus.dest);
        bus.res.skip = (dec_v == `FRU_DATA_ZERO);
      end
      fru_pkg::FRU_INCREMENT_SKIP_ZERO_OP: begin
        bus.res.result = inc_v;
        bus.res.write_file = to_file(bus.dest);
        bus.res.write_acc = !to_file(bus.dest);
        bus.res.skip = (inc_v == `FRU_DATA_ZERO);
      end
      default: begin
        bus.res = '0; // No operation
      end
    endcase
  end
endmodule : fru_alu
`default_nettype wire

//--- fru_unit_assertions.sv
// Checker for the file register unary operation unit
`timescale 1ns/1ps
`default_nettype none
module fru_checker (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic op_valid_i,
  input wire logic [2:0] op_i,
  input wire logic [6:0] file_addr_i,
  input wire logic dest_i,
  input wire logic [7:0] acc_o,
  input wire logic zero_o,
  input wire logic [7:0] file_data_o,
  input wire logic skip_o,
  input wire logic busy_o
);
  // ****************************************
  // Properties
  // ****************************************
  wire logic take = op_valid_i && !busy_o; // Operation accepted
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  skip_one_cycle_a:
    assert property (skip_o |=> !skip_o) else $error("skip longer than one cycle");
  skip_busy_a:
    assert property (skip_o |-> busy_o) else $error("skip without busy slot");
  busy_refuse_a:
    assert property (busy_o |=> $stable(acc_o) && $stable(zero_o) && !skip_o)
      else $error("op taken in squashed slot");
  clear_acc_a:
    assert property (take && op_i == 3'h4 |=> acc_o == 8'h00 && zero_o)
      else $error("accumulator clear failed");
  clear_file_a:
    assert property (take && op_i == 3'h2 |=> zero_o && !skip_o) else $error("clear zero flag");
  file_clear_read_a:
    assert property ((take && op_i == 3'h2) ##1 $stable(file_addr_i) |=> file_data_o == 8'h00)
      else $error("cleared register not read back as zero");
  skip_flags_a:
    assert property (take && (op_i == 3'h5 || op_i == 3'h6) |=> $stable(zero_o))
      else $error("skip op changed zero flag");
  file_dest_a:
    assert property (take && dest_i && op_i != 3'h4 |=> $stable(acc_o))
      else $error("file destination wrote accumulator");
  skip_on_zero_a:
    assert property (take && !dest_i && (op_i == 3'h5 || op_i == 3'h6)
      |=> skip_o == (acc_o == 8'h00)) else $error("skip decision wrong");
  zero_result_a:
    assert property (take && !dest_i && (op_i == 3'h1 || op_i == 3'h3)
      |=> zero_o == (acc_o == 8'h00)) else $error("zero flag wrong");
endmodule : fru_checker
bind fru_unit fru_checker chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .op_valid_i(op_valid_i), .op_i(op_i), .file_addr_i(file_addr_i), .dest_i(dest_i),
  .acc_o(acc_o), .zero_o(zero_o), .file_data_o(file_data_o), .skip_o(skip_o),
  .busy_o(busy_o));
`default_nettype wire

//--- test_file_register_unary_ops.sv
// Self-checking bench for the file register unary operation unit
`timescale 1ns/1ps
`default_nettype none
module test_file_register_unary_ops;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic op_valid_i = 1'b0;
  logic [2:0] op_i = 3'h0;
  logic [6:0] file_addr_i = 7'h00;
  logic dest_i = 1'b0;
  logic [7:0] acc_o, file_data_o;
  logic zero_o, skip_o, busy_o;
  int n_errors = 0;
  int tests_run = 0;
  fru_unit uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .file_addr_i(file_addr_i), .dest_i(dest_i), .acc_o(acc_o),
    .zero_o(zero_o), .file_data_o(file_data_o), .skip_o(skip_o), .busy_o(busy_o));
  // Clock at 4 ns period
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // Compare one value
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task final_report();
    $display("Errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // One op; poke offers a clear-acc in the following slot
  task run(input logic [2:0] op, input logic [6:0] a, input logic d, input logic poke,
    input logic [7:0] e_acc, input logic e_z, input logic e_skip, input logic [7:0] e_mem);
    logic [7:0] acc2;
    logic z2;
    acc2 = (poke && !e_skip) ? 8'h00 : e_acc; // Poked clear runs unless squashed
    z2 = (poke && !e_skip) ? 1'b1 : e_z;
    @(posedge ref_clk_i);
    op_valid_i <= 1'b1;
    op_i <= op;
    file_addr_i <= a;
    dest_i <= d;
    @(posedge ref_clk_i);
    op_valid_i <= poke;
    op_i <= 3'h4;
    #1;
    check(acc_o, e_acc);
    check({7'h00, zero_o}, {7'h00, e_z});
    check({6'h00, busy_o, skip_o}, {6'h00, e_skip, e_skip});
    @(posedge ref_clk_i);
    op_valid_i <= 1'b0;
    #1;
    check(acc_o, acc2);
    check({7'h00, zero_o}, {7'h00, z2});
    check({6'h00, busy_o, skip_o}, 8'h00);
    check(file_data_o, e_mem);
  endtask : run
  // Clear, complement and plain decrement
  task test_clear_complement();
    run(3'h2, 7'h7F, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 8'h00);
    run(3'h1, 7'h7F, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 8'hFF);
    run(3'h1, 7'h7F, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 8'hFF);
    run(3'h3, 7'h7F, 1'b0, 1'b0, 8'hFE, 1'b0, 1'b0, 8'hFF);
  endtask : test_clear_complement
  // Increment with skip, wrap from all ones
  task test_increment_skip();
    run(3'h6, 7'h7F, 1'b0, 1'b1, 8'h00, 1'b0, 1'b1, 8'hFF);
    run(3'h6, 7'h7F, 1'b1, 1'b0, 8'h00, 1'b0, 1'b1, 8'h00);
    run(3'h6, 7'h7F, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 8'h01);
  endtask : test_increment_skip
  // Decrement with skip and accumulator clear
  task test_decrement_skip();
    run(3'h5, 7'h7F, 1'b0, 1'b1, 8'h00, 1'b0, 1'b1, 8'h01);
    run(3'h3, 7'h7F, 1'b1, 1'b0, 8'h00, 1'b1, 1'b0, 8'h00);
    run(3'h5, 7'h7F, 1'b1, 1'b0, 8'h00, 1'b1, 1'b0, 8'hFF);
    run(3'h3, 7'h7F, 1'b0, 1'b0, 8'hFE, 1'b0, 1'b0, 8'hFF);
    run(3'h4, 7'h7F, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0, 8'hFF);
    run(3'h2, 7'h00, 1'b1, 1'b0, 8'h00, 1'b1, 1'b0, 8'h00);
    run(3'h5, 7'h00, 1'b0, 1'b1, 8'hFF, 1'b1, 1'b0, 8'h00);
  endtask : test_decrement_skip
  // Watchdog against a hang
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    test_clear_complement();
    test_increment_skip();
    test_decrement_skip();
    final_report();
  end
endmodule : test_file_register_unary_ops
`default_nettype wire
